// ---- pkg/ffp_map.svh ----
// Register offsets, field positions and reset values of the fast interrupt block
`ifndef FFP_MAP_SVH
`define FFP_MAP_SVH

// ************************************************************
// Register byte offsets
// ************************************************************
`define FFP_OFF_SMR_BASE   12'h000
`define FFP_OFF_SVR_BASE   12'h080
`define FFP_OFF_IVR        12'h100
`define FFP_OFF_FVR        12'h104
`define FFP_OFF_ISR        12'h108
`define FFP_OFF_IPR        12'h10C
`define FFP_OFF_IMR        12'h110
`define FFP_OFF_CISR       12'h114
`define FFP_OFF_IECR       12'h120
`define FFP_OFF_IDCR       12'h124
`define FFP_OFF_ICCR       12'h128
`define FFP_OFF_ISCR       12'h12C
`define FFP_OFF_EOICR      12'h130
`define FFP_OFF_SPU        12'h134
`define FFP_OFF_DCR        12'h138
`define FFP_OFF_FFER       12'h140
`define FFP_OFF_FFDR       12'h144
`define FFP_OFF_FFSR       12'h148

// ************************************************************
// Field positions
// ************************************************************
`define FFP_BLK_SMR        5'h00
`define FFP_BLK_SVR        5'h01
`define FFP_PRIOR_LSB      0
`define FFP_SOURCE_SENSITIVITY_LSB    5
`define FFP_DCR_PROTECT_ENABLE_BIT_BIT   0
`define FFP_DCR_GLOBAL_MASK_BIT_BIT   1
`define FFP_CISR_FIQ_BIT   0
`define FFP_CISR_IRQ_BIT   1

// ************************************************************
// Reset values
// ************************************************************
`define FFP_RST_WORD       32'h0000_0000
`define FFP_RST_PRIOR      3'h0
`define FFP_RST_SOURCE_SENSITIVITY    2'h0

`endif

// ---- pkg/ffp_pkg.sv ----
// Types shared by the fast interrupt block and its bench
package ffp_pkg;

  // Source sensitivity encoding held in a mode register
  typedef enum logic [1:0] {
    FFP_LOW_LEVEL  = 2'h0,
    FFP_NEG_EDGE   = 2'h1,
    FFP_HIGH_LEVEL = 2'h2,
    FFP_POS_EDGE   = 2'h3
  } ffp_sensitivity_t;

  // Avalon-MM request group as driven by the master
  typedef struct packed {
    logic        read;
    logic        write;
    logic [11:0] address;
    logic [31:0] writedata;
  } ffp_bus_req_t;

endpackage

// ---- hdl/ffp_core.sv ----
// Fast interrupt path, fast forcing, protect mode and general mask of the interrupt controller
//
// Implementation choices: the Avalon-MM slave port and the address map.
`timescale 1ns/10ps
`include "ffp_map.svh"

// Summary of operation
// - Fast vector read clears edge fast interrupt
// - Force enable/disable commands update force status
// - Forced source skips normal request and priority
// - Forced level source asserts fast request
// - Forced edge source asserts fast request
// - Forcing leaves source-0 pending bit untouched
// - Fast vector read returns source-0 vector
// - Forced edge sources clear only by clear command
// - Normal vector read never clears forced sources
// - Source 0 stays a fast request input
// - Protect bit set enables protect mode
// - Protect mode stacks only on vector write
// - Protect-mode lone reads change no context
// - Normal read selects, returns, pushes, acknowledges
// - Protect read selects, returns, memorizes only
// - Vector write ignored outside protect mode
// - No pending source returns spurious vector
// - General mask silences both request lines
// - Source-0 sensitivity selectable, priority stored only
// - Enable/disable commands steer mask bit 0
module ffp_core #(
  parameter int NSRC        = 32,
  parameter int STACK_DEPTH = 8
) (
  input  wire logic                 clk,              // System clock, 10 MHz
  input  wire logic                 rst,              // Asynchronous reset, active high
  input  wire logic                 ce,               // Clock enable, freezes all state when low
  input  wire ffp_pkg::ffp_bus_req_t avs_req,         // Avalon-MM read, write, address, data
  output logic [31:0]               avs_readdata,     // Avalon-MM read data
  output logic                      avs_waitrequest,  // Avalon-MM wait request
  input  wire logic [NSRC-1:0]      src_pin,          // Interrupt sources, asynchronous
  output logic                      fast_request_n,   // Fast request to core, active low
  output logic                      normal_request_n, // Normal request to core, active low
  output logic                      idle_wakeup       // Wake-up for an idle core, ignores general mask
);

  localparam int SW  = $clog2(NSRC);
  localparam int SPW = $clog2(STACK_DEPTH);
  localparam logic [SPW:0] SP_ONE = (SPW+1)'(1);

  // ************************************************************
  // Storage
  // ************************************************************
  logic                    ack_reg;
  logic [31:0]             rdata_reg;
  logic [NSRC-1:0]         sync1_reg;
  logic [NSRC-1:0]         sync2_reg;
  logic [NSRC-1:0]         prev_reg;
  logic [NSRC-1:0]         edge_pend_reg;
  logic [NSRC-1:0]         edge_pend_next;
  logic [NSRC-1:0]         mask_state_reg;
  logic [NSRC-1:0]         force_status_reg;
  logic [2:0]              prior_reg [NSRC];
  logic [1:0]              sens_reg [NSRC];
  logic [31:0]             vector_reg [NSRC];
  logic [31:0]             spurious_vector_reg;
  logic                    protect_enable_bit;
  logic                    global_mask_bit;
  logic [2:0]              lvl_stk_reg [STACK_DEPTH];
  logic [SW-1:0]           src_stk_reg [STACK_DEPTH];
  logic [SPW:0]            sp_reg;
  logic [SW-1:0]           memo_src_reg;
  logic                    memo_valid_reg;

  // ************************************************************
  // Bus decode
  // ************************************************************
  // ack_reg keeps a held request from being taken twice
  wire        take     = (avs_req.read | avs_req.write) & ~ack_reg;
  wire        rd_take  = take & avs_req.read;
  wire        wr_take  = take & avs_req.write;
  wire [11:0] addr     = avs_req.address;
  wire [31:0] wdata    = avs_req.writedata;
  wire [4:0]  idx      = addr[6:2];
  // Offsets past the last source hit no mode or vector register
  wire        idx_ok   = int'(idx) < NSRC;
  wire        smr_hit  = (addr[11:7] == `FFP_BLK_SMR) & idx_ok & (addr[1:0] == 2'h0);
  wire        svr_hit  = (addr[11:7] == `FFP_BLK_SVR) & idx_ok & (addr[1:0] == 2'h0);
  wire        ivr_rd   = rd_take & (addr == `FFP_OFF_IVR);
  wire        ivr_wr   = wr_take & (addr == `FFP_OFF_IVR);
  wire        fvr_rd   = rd_take & (addr == `FFP_OFF_FVR);
  wire        iecr_wr  = wr_take & (addr == `FFP_OFF_IECR);
  wire        idcr_wr  = wr_take & (addr == `FFP_OFF_IDCR);
  wire        iccr_wr  = wr_take & (addr == `FFP_OFF_ICCR);
  wire        iscr_wr  = wr_take & (addr == `FFP_OFF_ISCR);
  wire        eoicr_wr = wr_take & (addr == `FFP_OFF_EOICR);
  wire        spu_wr   = wr_take & (addr == `FFP_OFF_SPU);
  wire        dcr_wr   = wr_take & (addr == `FFP_OFF_DCR);
  wire        ffer_wr  = wr_take & (addr == `FFP_OFF_FFER);
  wire        ffdr_wr  = wr_take & (addr == `FFP_OFF_FFDR);

  // One wait cycle: the request is taken at the first edge, completes at the second
  assign avs_waitrequest = (avs_req.read | avs_req.write) & ~ack_reg;
  assign avs_readdata    = rdata_reg;

  // ************************************************************
  // Source conditioning
  // ************************************************************
  logic [NSRC-1:0] is_edge;
  logic [NSRC-1:0] level_on;
  logic [NSRC-1:0] edge_hit;
  logic [NSRC-1:0] pending_vec;
  logic [NSRC-1:0] cand_vec;

  always_comb begin
    for (int i = 0; i < NSRC; i++) begin
      is_edge[i]     = sens_reg[i][0];
      level_on[i]    = sens_reg[i][1] ? sync2_reg[i] : ~sync2_reg[i];
      edge_hit[i]    = sens_reg[i][1] ? (sync2_reg[i] & ~prev_reg[i])
                                      : (~sync2_reg[i] & prev_reg[i]);
      pending_vec[i] = is_edge[i] ? edge_pend_reg[i] : level_on[i];
    end
  end

  // Forced sources and source 0 never reach the priority logic
  assign cand_vec = pending_vec & mask_state_reg & ~force_status_reg
                    & {{(NSRC-1){1'b1}}, 1'b0};

  // ************************************************************
  // Priority selection
  // ************************************************************
  // Pointer is one bit wider than the index so full and empty differ
  wire [SPW-1:0] top_idx   = SPW'(sp_reg - SP_ONE);
  wire           cur_valid = (sp_reg != '0);
  wire [2:0]     cur_lvl   = lvl_stk_reg[top_idx];
  wire [SW-1:0]  cur_src   = cur_valid ? src_stk_reg[top_idx] : '0;

  logic          win_valid;
  logic [SW-1:0] win_src;
  logic [2:0]    win_lvl;

  // Strict greater-than keeps the lowest index on a priority tie
  always_comb begin
    win_valid = 1'b0;
    win_src   = '0;
    win_lvl   = '0;
    for (int i = 1; i < NSRC; i++) begin
      if (cand_vec[i] && (!cur_valid || prior_reg[i] > cur_lvl)
          && (!win_valid || prior_reg[i] > win_lvl)) begin
        win_valid = 1'b1;
        win_src   = SW'(i);
        win_lvl   = prior_reg[i];
      end
    end
  end

  // ************************************************************
  // Vector register side effects
  // ************************************************************
  // Normal mode pushes on the read, protect mode on the write of the memorized source
  wire          push_rd  = ivr_rd & ~protect_enable_bit & win_valid;
  wire          push_wr  = ivr_wr & protect_enable_bit & memo_valid_reg;
  wire          push_now = push_rd | push_wr;
  wire [SW-1:0] push_src = protect_enable_bit ? memo_src_reg : win_src;
  wire [2:0]    push_lvl = prior_reg[push_src];
  wire          stk_full = (sp_reg == (SPW+1)'(STACK_DEPTH));
  wire          pop_now  = eoicr_wr & cur_valid;

  logic [NSRC-1:0] clr_vec;
  logic [NSRC-1:0] set_vec;

  always_comb begin
    clr_vec = '0;
    if (iccr_wr) begin
      clr_vec = wdata[NSRC-1:0];
    end
    if (push_now) begin
      clr_vec[push_src] = 1'b1;
    end
    // A fast vector read clears source 0 only when it is edge typed
    if (fvr_rd && is_edge[0]) begin
      clr_vec[0] = 1'b1;
    end
    set_vec = edge_hit & is_edge;
    if (iscr_wr) begin
      set_vec = set_vec | (wdata[NSRC-1:0] & is_edge);
    end
  end

  // A new edge in the clearing cycle survives
  assign edge_pend_next = (edge_pend_reg & ~clr_vec) | set_vec;

  // ************************************************************
  // Request lines
  // ************************************************************
  // Registered lines give the core clean levels at one cycle of latency
  // General mask gates the lines only; idle wake-up sees every enabled source
  wire fiq_src0   = pending_vec[0] & mask_state_reg[0];
  wire fiq_forced = |(pending_vec & mask_state_reg & force_status_reg);
  wire fiq_req    = (fiq_src0 | fiq_forced) & ~global_mask_bit;
  wire irq_req    = win_valid & ~global_mask_bit;
  wire wake_req   = |(pending_vec & mask_state_reg);

  // ************************************************************
  // Read data selection
  // ************************************************************
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = '0;
    if (smr_hit) begin
      rd_mux[`FFP_PRIOR_LSB +: 3]   = prior_reg[idx[SW-1:0]];
      rd_mux[`FFP_SOURCE_SENSITIVITY_LSB +: 2] = sens_reg[idx[SW-1:0]];
    end else if (svr_hit) begin
      rd_mux = vector_reg[idx[SW-1:0]];
    end else begin
      unique case (addr)
        `FFP_OFF_IVR:  rd_mux = win_valid ? vector_reg[win_src]
                                          : spurious_vector_reg;
        `FFP_OFF_FVR:  rd_mux = vector_reg[0];
        `FFP_OFF_ISR:  rd_mux[SW-1:0] = cur_src;
        `FFP_OFF_IPR:  rd_mux[NSRC-1:0] = pending_vec;
        `FFP_OFF_IMR:  rd_mux[NSRC-1:0] = mask_state_reg;
        `FFP_OFF_CISR: begin
          rd_mux[`FFP_CISR_FIQ_BIT] = ~fast_request_n;
          rd_mux[`FFP_CISR_IRQ_BIT] = ~normal_request_n;
        end
        `FFP_OFF_SPU:  rd_mux = spurious_vector_reg;
        `FFP_OFF_DCR:  begin
          rd_mux[`FFP_DCR_PROTECT_ENABLE_BIT_BIT] = protect_enable_bit;
          rd_mux[`FFP_DCR_GLOBAL_MASK_BIT_BIT] = global_mask_bit;
        end
        `FFP_OFF_FFSR: rd_mux[NSRC-1:0] = force_status_reg;
        default:       rd_mux = '0;
      endcase
    end
  end

  // ************************************************************
  // Bus handshake and read data
  // ************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_reg   <= 1'b0;
      rdata_reg <= `FFP_RST_WORD;
    end else if (ce) begin
      ack_reg <= take;
      if (rd_take) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  // ************************************************************
  // Source synchronisers and pending state
  // ************************************************************
  // Only the second stage feeds logic; the first may be metastable.
  // Sources reset as level types, so the zeroed edge history cannot
  // latch a false edge before software programs an edge type.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_reg     <= '0;
      sync2_reg     <= '0;
      prev_reg      <= '0;
      edge_pend_reg <= '0;
    end else if (ce) begin
      sync1_reg     <= src_pin;
      sync2_reg     <= sync1_reg;
      prev_reg      <= sync2_reg;
      edge_pend_reg <= edge_pend_next;
    end
  end

  // ************************************************************
  // Control registers
  // ************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mask_state_reg      <= '0;
      force_status_reg    <= '0;
      spurious_vector_reg <= `FFP_RST_WORD;
      protect_enable_bit  <= 1'b0;
      global_mask_bit     <= 1'b0;
    end else if (ce) begin
      if (iecr_wr) begin
        mask_state_reg <= mask_state_reg | wdata[NSRC-1:0];
      end else if (idcr_wr) begin
        mask_state_reg <= mask_state_reg & ~wdata[NSRC-1:0];
      end
      // Source 0 is the fast source already; forcing it has no meaning
      if (ffer_wr) begin
        force_status_reg <= (force_status_reg | wdata[NSRC-1:0])
                            & {{(NSRC-1){1'b1}}, 1'b0};
      end else if (ffdr_wr) begin
        force_status_reg <= force_status_reg & ~wdata[NSRC-1:0];
      end
      if (spu_wr) begin
        spurious_vector_reg <= wdata;
      end
      if (dcr_wr) begin
        protect_enable_bit <= wdata[`FFP_DCR_PROTECT_ENABLE_BIT_BIT];
        global_mask_bit    <= wdata[`FFP_DCR_GLOBAL_MASK_BIT_BIT];
      end
    end
  end

  // ************************************************************
  // Mode and vector registers
  // ************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NSRC; i++) begin
        prior_reg[i]  <= `FFP_RST_PRIOR;
        sens_reg[i]   <= `FFP_RST_SOURCE_SENSITIVITY;
        vector_reg[i] <= `FFP_RST_WORD;
      end
    end else if (ce) begin
      if (wr_take && smr_hit) begin
        prior_reg[idx[SW-1:0]] <= wdata[`FFP_PRIOR_LSB +: 3];
        sens_reg[idx[SW-1:0]]  <= wdata[`FFP_SOURCE_SENSITIVITY_LSB +: 2];
      end
      if (wr_take && svr_hit) begin
        vector_reg[idx[SW-1:0]] <= wdata;
      end
    end
  end

  // ************************************************************
  // Priority stack and protect-mode memory
  // ************************************************************
  // A push into a full stack is dropped rather than corrupting older levels
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sp_reg         <= '0;
      memo_src_reg   <= '0;
      memo_valid_reg <= 1'b0;
      for (int i = 0; i < STACK_DEPTH; i++) begin
        lvl_stk_reg[i] <= `FFP_RST_PRIOR;
        src_stk_reg[i] <= '0;
      end
    end else if (ce) begin
      if (push_now && !stk_full) begin
        lvl_stk_reg[sp_reg[SPW-1:0]] <= push_lvl;
        src_stk_reg[sp_reg[SPW-1:0]] <= push_src;
        sp_reg                       <= sp_reg + SP_ONE;
      end else if (pop_now) begin
        sp_reg <= sp_reg - SP_ONE;
      end
      // A spurious protect-mode read forgets the winner, so no push follows
      if (ivr_rd && protect_enable_bit) begin
        memo_src_reg   <= win_src;
        memo_valid_reg <= win_valid;
      end else if (push_wr) begin
        memo_valid_reg <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Core-facing outputs
  // ************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fast_request_n   <= 1'b1;
      normal_request_n <= 1'b1;
      idle_wakeup      <= 1'b0;
    end else if (ce) begin
      fast_request_n   <= ~fiq_req;
      normal_request_n <= ~irq_req;
      idle_wakeup      <= wake_req;
    end
  end

endmodule

// ---- verification/ffp_core_assertions.sv ----
// Concurrent checks on the ports of the fast interrupt block
`timescale 1ns/10ps
`include "ffp_map.svh"
module ffp_core_assertions #(
  parameter int NSRC = 32
) (
  input wire logic                  clk,              // System clock
  input wire logic                  rst,              // Async reset, active high
  input wire logic                  ce,               // Clock enable
  input wire ffp_pkg::ffp_bus_req_t avs_req,          // Bus request group
  input wire logic [31:0]           avs_readdata,     // Bus read data
  input wire logic                  avs_waitrequest,  // Bus wait request
  input wire logic [NSRC-1:0]       src_pin,          // Interrupt sources
  input wire logic                  fast_request_n,   // Fast line, active low
  input wire logic                  normal_request_n, // Normal line, active low
  input wire logic                  idle_wakeup       // Idle wake-up
);
  // ************************************************************
  // Shadow of the registers written over the bus
  // ************************************************************
  wire logic        wr_take = avs_req.write & avs_waitrequest & ce;
  wire logic        rd_done = avs_req.read & ~avs_waitrequest & ce;
  wire logic [11:0] adr     = avs_req.address;
  wire logic [31:0] wd      = avs_req.writedata;
  logic [31:0] svr0_reg;
  logic [31:0] spu_reg;
  logic [31:0] ffsr_reg;
  logic [31:0] imr_reg;
  logic [31:0] smr0_reg;
  logic [1:0]  dcr_reg;
  // Forced sources also need their enable bit before they reach the fast line
  wire logic fast_cause = (imr_reg[0] | (|(ffsr_reg & imr_reg))) & ~dcr_reg[1];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      svr0_reg <= 32'h0000_0000;
      spu_reg  <= 32'h0000_0000;
      ffsr_reg <= 32'h0000_0000;
      imr_reg  <= 32'h0000_0000;
      smr0_reg <= 32'h0000_0000;
      dcr_reg  <= 2'h0;
    end else if (wr_take) begin
      if (adr == `FFP_OFF_SVR_BASE) svr0_reg <= wd;
      if (adr == `FFP_OFF_SPU) spu_reg <= wd;
      if (adr == `FFP_OFF_FFER) ffsr_reg <= ffsr_reg | {wd[31:1], 1'b0};
      if (adr == `FFP_OFF_FFDR) ffsr_reg <= ffsr_reg & ~wd;
      if (adr == `FFP_OFF_IECR) imr_reg <= imr_reg | wd;
      if (adr == `FFP_OFF_IDCR) imr_reg <= imr_reg & ~wd;
      if (adr == `FFP_OFF_SMR_BASE) smr0_reg <= wd & 32'h0000_0067;
      if (adr == `FFP_OFF_DCR) dcr_reg <= wd[1:0];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_one_wait_state: assert property ((avs_req.read | avs_req.write) && avs_waitrequest && ce
    |=> !avs_waitrequest) else $error("bus answer not after one wait");
  a_fvr_source0: assert property (rd_done && adr == `FFP_OFF_FVR |-> avs_readdata == svr0_reg)
    else $error("fast vector read differs from source 0 vector");
  a_ffsr_follows_cmds: assert property (rd_done && adr == `FFP_OFF_FFSR
    |-> avs_readdata == ffsr_reg) else $error("force status differs from commands");
  a_imr_follows_cmds: assert property (rd_done && adr == `FFP_OFF_IMR
    |-> avs_readdata == imr_reg) else $error("mask state differs from commands");
  a_smr0_stored: assert property (rd_done && adr == `FFP_OFF_SMR_BASE
    |-> avs_readdata == smr0_reg) else $error("source 0 mode not stored");
  a_dcr_stored: assert property (rd_done && adr == `FFP_OFF_DCR
    |-> avs_readdata[1:0] == dcr_reg) else $error("debug control not stored");
  a_spu_stored: assert property (rd_done && adr == `FFP_OFF_SPU |-> avs_readdata == spu_reg)
    else $error("spurious vector not stored");
  a_mask_both_lines: assert property (dcr_reg[1] && $past(dcr_reg[1])
    |-> fast_request_n && normal_request_n) else $error("request line active under mask");
  a_fast_has_cause: assert property (!fast_request_n |-> $past(fast_cause))
    else $error("fast line active without enabled cause");
endmodule

// ---- verification/ffp_cpu_model.sv ----
// Processor core model: bus master of the register interface
`timescale 1ns/10ps
module ffp_cpu_model (
  input  wire logic            clk,             // System clock
  output ffp_pkg::ffp_bus_req_t avs_req,        // Bus request group
  input  wire logic [31:0]     avs_readdata,    // Bus read data
  input  wire logic            avs_waitrequest  // Bus wait request
);
  initial avs_req = '0;

  // ************************************************************
  // One bus transfer; held until waitrequest is seen low
  // ************************************************************
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    avs_req <= '{read: ~w, write: w, address: a, writedata: d};
    // Only the bench watchdog ends a wait that never completes
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_req <= '0;
  endtask
endmodule

// ---- verification/ffp_core_tb.sv ----
// Self-checking bench of the fast interrupt block
`timescale 1ns/10ps
`include "ffp_map.svh"
module ffp_core_tb;
  localparam int NSRC = 32;
  typedef struct packed {
    logic [11:0] waddr;
    logic [31:0] wdata;
    logic [11:0] raddr;
    logic [31:0] rexp;
  } ffp_row_t;

  logic                  clk;
  logic                  rst;
  logic                  ce;
  ffp_pkg::ffp_bus_req_t avs_req;
  logic [31:0]           avs_readdata;
  logic                  avs_waitrequest;
  logic [NSRC-1:0]       src_pin;
  logic                  fast_request_n;
  logic                  normal_request_n;
  logic                  idle_wakeup;
  logic [31:0]           rd;
  int                    mismatches = 0;
  int                    comparisons = 0;
  ffp_row_t rows [9] = '{
    '{`FFP_OFF_SVR_BASE, 32'h1234_5678, `FFP_OFF_FVR, 32'h1234_5678},
    '{`FFP_OFF_SPU, 32'hCAFE_0000, `FFP_OFF_SPU, 32'hCAFE_0000},
    '{`FFP_OFF_FFER, 32'h0000_000F, `FFP_OFF_FFSR, 32'h0000_000E},
    '{`FFP_OFF_FFDR, 32'h0000_0006, `FFP_OFF_FFSR, 32'h0000_0008},
    '{`FFP_OFF_IECR, 32'h0000_0001, `FFP_OFF_IMR, 32'h0000_0001},
    '{`FFP_OFF_IDCR, 32'h0000_0001, `FFP_OFF_IMR, 32'h0000_0000},
    '{`FFP_OFF_SMR_BASE, 32'h0000_0067, `FFP_OFF_SMR_BASE, 32'h0000_0067},
    '{12'h118, 32'hFFFF_FFFF, 12'h118, 32'h0000_0000},
    '{`FFP_OFF_IVR, 32'hAAAA_0000, `FFP_OFF_ISR, 32'h0000_0000}
  };

  ffp_core #(.NSRC(NSRC)) i_ffp_core (
    .clk(clk), .rst(rst), .ce(ce), .avs_req(avs_req), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .src_pin(src_pin), .fast_request_n(fast_request_n),
    .normal_request_n(normal_request_n), .idle_wakeup(idle_wakeup));
  ffp_cpu_model i_ffp_cpu_model (
    .clk(clk), .avs_req(avs_req), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));

  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    i_ffp_cpu_model.bus(1'b1, a, d, rd);
  endtask
  task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] e);
    i_ffp_cpu_model.bus(1'b0, a, 32'h0000_0000, rd);
    check(n, rd, e);
  endtask
  // Five edges cover the worst pin-to-line latency of four
  task automatic lines(input string n, input logic f, input logic r);
    repeat (5) @(posedge clk);
    check(n, {30'h0, fast_request_n, normal_request_n}, {30'h0, f, r});
  endtask
  task automatic setsrc(input int i, input logic v);
    @(posedge clk);
    src_pin[i] <= v;
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    stop_test;
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    // Idle high keeps low-level sources quiet; source 0 starts low
    src_pin = 32'hFFFF_FFFE;
    repeat (16) @(posedge clk);
    check("reset", {29'h0, fast_request_n, normal_request_n, idle_wakeup}, 32'h0000_0006);
    rst <= 1'b0;
    foreach (rows[i]) begin
      wr(rows[i].waddr, rows[i].wdata);
      rdc("row", rows[i].raddr, rows[i].rexp);
    end
    wr(`FFP_OFF_IECR, 32'h0000_0001);
    setsrc(0, 1'b1);
    lines("fast edge", 1'b0, 1'b1);
    rdc("fvr", `FFP_OFF_FVR, 32'h1234_5678);
    lines("fast edge clear", 1'b1, 1'b1);
    wr(`FFP_OFF_SMR_BASE, 32'h0000_0040);
    lines("fast level", 1'b0, 1'b1);
    rdc("fvr", `FFP_OFF_FVR, 32'h1234_5678);
    lines("fast level kept", 1'b0, 1'b1);
    setsrc(0, 1'b0);
    lines("fast level gone", 1'b1, 1'b1);
    wr(12'h00C, 32'h0000_0020);
    wr(`FFP_OFF_IECR, 32'h0000_0008);
    setsrc(3, 1'b0);
    lines("forced edge", 1'b0, 1'b1);
    rdc("pending", `FFP_OFF_IPR, 32'h0000_0008);
    rdc("fvr forced", `FFP_OFF_FVR, 32'h1234_5678);
    lines("forced after fvr", 1'b0, 1'b1);
    rdc("ivr forced", `FFP_OFF_IVR, 32'hCAFE_0000);
    lines("forced after ivr", 1'b0, 1'b1);
    wr(`FFP_OFF_ICCR, 32'h0000_0008);
    lines("forced cleared", 1'b1, 1'b1);
    wr(`FFP_OFF_EOICR, 32'h0000_0000);
    setsrc(3, 1'b1);
    wr(`FFP_OFF_FFER, 32'h0000_0010);
    wr(`FFP_OFF_IECR, 32'h0000_0010);
    rdc("ffsr", `FFP_OFF_FFSR, 32'h0000_0018);
    setsrc(4, 1'b0);
    lines("forced level", 1'b0, 1'b1);
    setsrc(4, 1'b1);
    lines("forced level gone", 1'b1, 1'b1);
    wr(12'h014, 32'h0000_0005);
    wr(12'h094, 32'h5555_0000);
    wr(`FFP_OFF_IECR, 32'h0000_0020);
    setsrc(5, 1'b0);
    lines("normal", 1'b1, 1'b0);
    wr(`FFP_OFF_DCR, 32'h0000_0001);
    rdc("dcr", `FFP_OFF_DCR, 32'h0000_0001);
    for (int k = 0; k < 2; k++) begin
      rdc("ivr protect_enable_bit", `FFP_OFF_IVR, 32'h5555_0000);
      rdc("isr protect_enable_bit", `FFP_OFF_ISR, 32'h0000_0000);
    end
    wr(`FFP_OFF_IVR, 32'h0000_0000);
    rdc("isr write", `FFP_OFF_ISR, 32'h0000_0005);
    wr(`FFP_OFF_EOICR, 32'h0000_0000);
    wr(`FFP_OFF_DCR, 32'h0000_0000);
    rdc("ivr normal", `FFP_OFF_IVR, 32'h5555_0000);
    rdc("isr normal", `FFP_OFF_ISR, 32'h0000_0005);
    wr(`FFP_OFF_EOICR, 32'h0000_0000);
    wr(`FFP_OFF_DCR, 32'h0000_0002);
    lines("masked", 1'b1, 1'b1);
    check("wake", {31'h0, idle_wakeup}, 32'h0000_0001);
    wr(`FFP_OFF_DCR, 32'h0000_0000);
    lines("unmasked", 1'b1, 1'b0);
    setsrc(5, 1'b1);
    lines("quiet", 1'b1, 1'b1);
    // A low clock enable must hold the lines while the source moves
    ce <= 1'b0;
    setsrc(5, 1'b0);
    lines("frozen", 1'b1, 1'b1);
    ce <= 1'b1;
    lines("thawed", 1'b1, 1'b0);
    setsrc(5, 1'b1);
    lines("quiet again", 1'b1, 1'b1);
    rdc("spurious", `FFP_OFF_IVR, 32'hCAFE_0000);
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    rdc("ffsr reset", `FFP_OFF_FFSR, 32'h0000_0000);
    stop_test;
  end
endmodule

bind ffp_core ffp_core_assertions #(.NSRC(NSRC)) i_ffp_core_assertions (
  .clk(clk), .rst(rst), .ce(ce), .avs_req(avs_req), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .src_pin(src_pin), .fast_request_n(fast_request_n),
  .normal_request_n(normal_request_n), .idle_wakeup(idle_wakeup));
